// ===== core/tfam_pkg.sv
// constants, offsets and types of the thermal flag and analog selector block
package tfam_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 20;

	// register byte addresses
	localparam logic [4:0] REG_EVENT = 5'h00;
	localparam logic [4:0] REG_LIVE = 5'h04;
	localparam logic [4:0] REG_BLOCK = 5'h08;
	localparam logic [4:0] REG_WATCH = 5'h0c;
	localparam logic [4:0] REG_SELECTOR = 5'h10;
	localparam logic [4:0] REG_STATE = 5'h14;

	// field positions
	localparam int N_LEVELS = 6;
	localparam int WATCH_EN_BIT = 0;
	localparam int WATCH_AON_BIT = 1;
	localparam int SEL_CHAN_LSB = 0;
	localparam int SEL_EN_BIT = 5;
	localparam int ST_POWER_BIT = 0;
	localparam int ST_CONT_BIT = 1;
	localparam int ST_SETTLED_BIT = 2;
	localparam int ST_DRIVE_BIT = 3;

	// values after reset
	localparam logic [1:0] WATCH_RST = 2'h1;
	localparam logic [5:0] BLOCK_RST = 6'h00;
	localparam logic [5:0] SELECTOR_RST = 6'h00;

	// times in ns as printed, and derived cycle counts (least times rounded up)
	localparam int HEAT_WINDOW_NS = 450000;
	localparam int HEAT_INTERVAL_NS = 3000000;
	localparam int SELECTOR_SETTLE_NS = 50000;
	localparam int HEAT_DEBOUNCE_NS = 10000;
	localparam int HEAT_WINDOW_CYC = (HEAT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HEAT_INTERVAL_CYC = (HEAT_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECTOR_SETTLE_CYC =
		(SELECTOR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HEAT_DEBOUNCE_CYC = (HEAT_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// analog selector channel codes
	typedef enum logic [4:0] {
		SRC_NONE = 5'h00,
		SRC_SUPPLY_IN = 5'h01,
		SRC_KEEPALIVE_ONE = 5'h02,
		SRC_KEEPALIVE_TWO = 5'h03,
		SRC_BUCK1_FB = 5'h04,
		SRC_BUCK2_FB = 5'h05,
		SRC_BUCK3_FB = 5'h06,
		SRC_BUCK4_FB = 5'h07,
		SRC_BUCK5_FB = 5'h08,
		SRC_LINEAR_REG1 = 5'h0b,
		SRC_LINEAR_REG2 = 5'h0c,
		SRC_DIE_CENTRE = 5'h0f,
		SRC_DIE_BUCK1 = 5'h10,
		SRC_DIE_BUCK2 = 5'h11,
		SRC_DIE_BUCK3 = 5'h12,
		SRC_DIE_BUCK4 = 5'h13,
		SRC_DIE_BUCK5 = 5'h14,
		SRC_DIE_LINEAR = 5'h17
	} tfam_src_t;

	// sampling scheduler states
	typedef enum logic [3:0] {
		HW_OFF = 4'b0001,
		HW_WINDOW = 4'b0010,
		HW_GAP = 4'b0100,
		HW_CONT = 4'b1000
	} tfam_watch_state_t;

endpackage

// ===== core/tfam_watch_if.sv
// link between the scheduler and the threshold sensing logic
`timescale 1ns/100ps
`default_nettype none
interface tfam_watch_if;
	logic sense_enable;
	logic sense_active;
	logic [5:0] live_level;
	logic [5:0] level_rise;

	modport ctrl (
		output sense_enable,
		output sense_active,
		input live_level,
		input level_rise
	);
	modport sense (
		input sense_enable,
		input sense_active,
		output live_level,
		output level_rise
	);
endinterface
`default_nettype wire

// ===== core/tfam_level_sense.sv
// per-threshold synchroniser, hysteresis and debounce of the comparator pins
`timescale 1ns/100ps
`default_nettype none
module tfam_level_sense (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// comparator pins
	input wire logic [5:0] i_heat_rise_cmp,
	input wire logic [5:0] i_heat_fall_cmp,
	// scheduler side
	tfam_watch_if.sense watch
);
	localparam logic [9:0] DB_LAST = 10'(tfam_pkg::HEAT_DEBOUNCE_CYC - 1);

	logic [5:0] rise_meta_reg;
	logic [5:0] rise_sync_reg;
	logic [5:0] fall_meta_reg;
	logic [5:0] fall_sync_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rise_meta_reg <= 6'h00;
			rise_sync_reg <= 6'h00;
			fall_meta_reg <= 6'h00;
			fall_sync_reg <= 6'h00;
		end else begin
			rise_meta_reg <= i_heat_rise_cmp;
			rise_sync_reg <= rise_meta_reg;
			fall_meta_reg <= i_heat_fall_cmp;
			fall_sync_reg <= fall_meta_reg;
		end
	end

	genvar g;
	generate
		for (g = 0; g < tfam_pkg::N_LEVELS; g++) begin : g_level
			logic live_reg;
			logic rise_reg;
			logic [9:0] db_reg;
			logic want;

			// set on the threshold, released only below threshold minus hysteresis
			assign want = live_reg ? fall_sync_reg[g] : rise_sync_reg[g];

			always_ff @(posedge i_core_clk) begin
				if (i_sys_rst) begin
					live_reg <= 1'b0;
					rise_reg <= 1'b0;
					db_reg <= 10'h000;
				end else if (!watch.sense_enable) begin
					// monitor off: nothing is sensed
					live_reg <= 1'b0;
					rise_reg <= 1'b0;
					db_reg <= 10'h000;
				end else if (!watch.sense_active || want == live_reg) begin
					// outside a sampling window the last level is held
					rise_reg <= 1'b0;
					db_reg <= 10'h000;
				end else if (db_reg == DB_LAST) begin
					live_reg <= want;
					rise_reg <= want;
					db_reg <= 10'h000;
				end else begin
					rise_reg <= 1'b0;
					db_reg <= db_reg + 10'h001;
				end
			end

			assign watch.live_level[g] = live_reg;
			assign watch.level_rise[g] = rise_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== core/tfam_top.sv
// thermal threshold flags, monitor scheduling and analog selector control
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module tfam_top #(
	parameter int unsigned P_WINDOW_CYC = tfam_pkg::HEAT_WINDOW_CYC,
	parameter int unsigned P_INTERVAL_CYC = tfam_pkg::HEAT_INTERVAL_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// power state from the sequencer
	input wire logic i_sys_on,
	input wire logic i_standby,
	// threshold comparator pins
	input wire logic [5:0] i_heat_rise_cmp,
	input wire logic [5:0] i_heat_fall_cmp,
	// thermal monitor power
	output logic o_heat_watch_power,
	// analog selector control
	output logic [4:0] o_analog_selector_route,
	output logic o_analog_selector_drive,
	output logic o_analog_selector_pull_down,
	output logic o_analog_selector_settled,
	// interrupt
	output logic o_irq
);
	localparam logic [17:0] WIN_LAST = 18'(P_WINDOW_CYC - 1);
	localparam logic [17:0] GAP_LAST = 18'(P_INTERVAL_CYC - P_WINDOW_CYC - 1);
	localparam logic [11:0] SETTLE_LAST = 12'(tfam_pkg::SELECTOR_SETTLE_CYC - 1);

	tfam_watch_if watch_link ();

	// bus handshake
	logic ack_reg;
	logic req;
	logic wr_take;
	logic [31:0] rd_next;
	logic [31:0] rd_reg;

	// software registers
	logic [5:0] heat_event_flag_reg;
	logic [5:0] heat_event_flag_next;
	logic [5:0] heat_irq_block_reg;
	logic heat_watch_enable_reg;
	logic heat_watch_always_on_reg;
	logic analog_selector_enable_reg;
	logic [4:0] analog_selector_channel_reg;

	// scheduler
	tfam_pkg::tfam_watch_state_t watch_state_reg;
	tfam_pkg::tfam_watch_state_t watch_state_next;
	logic [17:0] watch_cnt_reg;
	logic [17:0] watch_cnt_next;
	logic cont_mode;
	logic power_reg;

	// selector
	logic [4:0] route_next;
	logic route_known;
	logic [4:0] route_reg;
	logic drive_reg;
	logic pull_down_reg;
	logic sys_on_prev_reg;
	logic settle_restart;
	logic [11:0] settle_cnt_reg;
	logic settled_reg;
	logic irq_reg;

	// avalon: one wait cycle then answer, writes take effect at that edge
	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_reg;
	assign wr_take = i_avs_write & ack_reg & i_avs_byteenable[0];
	assign o_avs_readdata = rd_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		case (i_avs_address)
			tfam_pkg::REG_EVENT: begin
				rd_next[5:0] = heat_event_flag_reg;
			end
			tfam_pkg::REG_LIVE: begin
				rd_next[5:0] = watch_link.live_level;
			end
			tfam_pkg::REG_BLOCK: begin
				rd_next[5:0] = heat_irq_block_reg;
			end
			tfam_pkg::REG_WATCH: begin
				rd_next[tfam_pkg::WATCH_EN_BIT] = heat_watch_enable_reg;
				rd_next[tfam_pkg::WATCH_AON_BIT] = heat_watch_always_on_reg;
			end
			tfam_pkg::REG_SELECTOR: begin
				rd_next[tfam_pkg::SEL_CHAN_LSB +: 5] = analog_selector_channel_reg;
				rd_next[tfam_pkg::SEL_EN_BIT] = analog_selector_enable_reg;
			end
			tfam_pkg::REG_STATE: begin
				rd_next[tfam_pkg::ST_POWER_BIT] = power_reg;
				rd_next[tfam_pkg::ST_CONT_BIT] = cont_mode;
				rd_next[tfam_pkg::ST_SETTLED_BIT] = settled_reg;
				rd_next[tfam_pkg::ST_DRIVE_BIT] = drive_reg;
			end
			default: begin
				// unmapped reads answer zero
				rd_next = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rd_reg <= 32'h0000_0000;
		end else if (req & ~ack_reg) begin
			rd_reg <= rd_next;
		end
	end

	// control registers
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			heat_irq_block_reg <= tfam_pkg::BLOCK_RST;
			heat_watch_enable_reg <= tfam_pkg::WATCH_RST[tfam_pkg::WATCH_EN_BIT];
			heat_watch_always_on_reg <= tfam_pkg::WATCH_RST[tfam_pkg::WATCH_AON_BIT];
			analog_selector_enable_reg <= tfam_pkg::SELECTOR_RST[tfam_pkg::SEL_EN_BIT];
			analog_selector_channel_reg <= tfam_pkg::SELECTOR_RST[4:0];
		end else if (wr_take) begin
			case (i_avs_address)
				tfam_pkg::REG_BLOCK: begin
					heat_irq_block_reg <= i_avs_writedata[5:0];
				end
				tfam_pkg::REG_WATCH: begin
					heat_watch_enable_reg <= i_avs_writedata[tfam_pkg::WATCH_EN_BIT];
					heat_watch_always_on_reg <= i_avs_writedata[tfam_pkg::WATCH_AON_BIT];
				end
				tfam_pkg::REG_SELECTOR: begin
					analog_selector_enable_reg <= i_avs_writedata[tfam_pkg::SEL_EN_BIT];
					analog_selector_channel_reg <=
						i_avs_writedata[tfam_pkg::SEL_CHAN_LSB +: 5];
				end
				default: begin
					// other addresses hold no writable control
					heat_irq_block_reg <= heat_irq_block_reg;
				end
			endcase
		end
	end

	// event flags: write one to clear, a new crossing wins over the clear
	always_comb begin
		heat_event_flag_next = heat_event_flag_reg;
		if (wr_take && i_avs_address == tfam_pkg::REG_EVENT) begin
			heat_event_flag_next = heat_event_flag_next & ~i_avs_writedata[5:0];
		end
		heat_event_flag_next = heat_event_flag_next | watch_link.level_rise;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			heat_event_flag_reg <= 6'h00;
		end else begin
			heat_event_flag_reg <= heat_event_flag_next;
		end
	end

	// mask gates only the request, flags and live levels carry on
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(heat_event_flag_reg & ~heat_irq_block_reg);
		end
	end
	assign o_irq = irq_reg;

	// monitor scheduler; standby never runs continuously
	assign cont_mode = heat_watch_always_on_reg & ~i_standby;

	always_comb begin
		watch_state_next = watch_state_reg;
		watch_cnt_next = watch_cnt_reg + 18'h00001;
		case (watch_state_reg)
			tfam_pkg::HW_OFF: begin
				watch_cnt_next = 18'h00000;
				if (heat_watch_enable_reg) begin
					watch_state_next = cont_mode ? tfam_pkg::HW_CONT : tfam_pkg::HW_WINDOW;
				end
			end
			tfam_pkg::HW_CONT: begin
				watch_cnt_next = 18'h00000;
				if (!cont_mode) begin
					watch_state_next = tfam_pkg::HW_WINDOW;
				end
			end
			tfam_pkg::HW_WINDOW: begin
				if (cont_mode) begin
					watch_state_next = tfam_pkg::HW_CONT;
					watch_cnt_next = 18'h00000;
				end else if (watch_cnt_reg == WIN_LAST) begin
					watch_state_next = tfam_pkg::HW_GAP;
					watch_cnt_next = 18'h00000;
				end
			end
			tfam_pkg::HW_GAP: begin
				if (cont_mode) begin
					watch_state_next = tfam_pkg::HW_CONT;
					watch_cnt_next = 18'h00000;
				end else if (watch_cnt_reg == GAP_LAST) begin
					watch_state_next = tfam_pkg::HW_WINDOW;
					watch_cnt_next = 18'h00000;
				end
			end
			default: begin
				watch_state_next = tfam_pkg::HW_OFF;
				watch_cnt_next = 18'h00000;
			end
		endcase
		if (!heat_watch_enable_reg) begin
			watch_state_next = tfam_pkg::HW_OFF;
			watch_cnt_next = 18'h00000;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			watch_state_reg <= tfam_pkg::HW_OFF;
			watch_cnt_reg <= 18'h00000;
			power_reg <= 1'b0;
		end else begin
			watch_state_reg <= watch_state_next;
			watch_cnt_reg <= watch_cnt_next;
			power_reg <= (watch_state_next == tfam_pkg::HW_CONT) ||
				(watch_state_next == tfam_pkg::HW_WINDOW);
		end
	end

	assign o_heat_watch_power = power_reg;
	assign watch_link.sense_enable = heat_watch_enable_reg;
	assign watch_link.sense_active = power_reg;

	tfam_level_sense u_level_sense (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_heat_rise_cmp(i_heat_rise_cmp),
		.i_heat_fall_cmp(i_heat_fall_cmp),
		.watch(watch_link.sense)
	);

	// channel decode, unknown codes route nothing
	always_comb begin
		route_next = 5'h00;
		route_known = 1'b1;
		case (analog_selector_channel_reg)
			tfam_pkg::SRC_SUPPLY_IN,
			tfam_pkg::SRC_KEEPALIVE_ONE,
			tfam_pkg::SRC_KEEPALIVE_TWO: begin
				route_next = analog_selector_channel_reg;
			end
			tfam_pkg::SRC_BUCK1_FB,
			tfam_pkg::SRC_BUCK2_FB,
			tfam_pkg::SRC_BUCK3_FB,
			tfam_pkg::SRC_BUCK4_FB,
			tfam_pkg::SRC_BUCK5_FB: begin
				route_next = analog_selector_channel_reg;
			end
			tfam_pkg::SRC_LINEAR_REG1,
			tfam_pkg::SRC_LINEAR_REG2: begin
				route_next = analog_selector_channel_reg;
			end
			tfam_pkg::SRC_DIE_CENTRE,
			tfam_pkg::SRC_DIE_BUCK1,
			tfam_pkg::SRC_DIE_BUCK2,
			tfam_pkg::SRC_DIE_BUCK3,
			tfam_pkg::SRC_DIE_BUCK4,
			tfam_pkg::SRC_DIE_BUCK5,
			tfam_pkg::SRC_DIE_LINEAR: begin
				route_next = analog_selector_channel_reg;
			end
			tfam_pkg::SRC_NONE: begin
				route_known = 1'b0;
			end
			default: begin
				route_known = 1'b0;
			end
		endcase
		if (!analog_selector_enable_reg || !i_sys_on) begin
			route_next = 5'h00;
			route_known = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			route_reg <= 5'h00;
			drive_reg <= 1'b0;
			pull_down_reg <= 1'b1;
		end else begin
			route_reg <= route_next;
			drive_reg <= route_known;
			// disabled pulls low; enabled but idle floats
			pull_down_reg <= ~analog_selector_enable_reg;
		end
	end

	assign o_analog_selector_route = route_reg;
	assign o_analog_selector_drive = drive_reg;
	assign o_analog_selector_pull_down = pull_down_reg;

	// settle timer: reader should wait for settled after any change
	assign settle_restart = ~drive_reg | (route_reg != route_next) | (i_sys_on & ~sys_on_prev_reg);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			sys_on_prev_reg <= 1'b0;
			settle_cnt_reg <= 12'h000;
			settled_reg <= 1'b0;
		end else begin
			sys_on_prev_reg <= i_sys_on;
			if (settle_restart) begin
				settle_cnt_reg <= 12'h000;
				settled_reg <= 1'b0;
			end else if (settle_cnt_reg == SETTLE_LAST) begin
				settled_reg <= 1'b1;
			end else begin
				settle_cnt_reg <= settle_cnt_reg + 12'h001;
			end
		end
	end

	assign o_analog_selector_settled = settled_reg;

endmodule
`default_nettype wire

// ===== bench/tfam_sampler.sv
// converter model sampling the analog selector pin
`timescale 1ns/100ps
`default_nettype none
module tfam_sampler #(
	parameter int P_SETTLE = tfam_pkg::SELECTOR_SETTLE_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// pin state
	input wire logic i_drive,
	input wire logic i_pull_down,
	input wire logic [4:0] i_route,
	// conversion result
	output logic [4:0] o_reading,
	output logic o_valid
);
	logic [4:0] level;
	logic [4:0] last_route;
	int wait_cnt;

	// a floating pin changes every cycle, so a stale value never passes
	always_ff @(posedge i_clk) begin
		if (i_rst || i_pull_down) begin
			level <= 5'h00;
		end else if (i_drive) begin
			level <= i_route;
		end else begin
			level <= ~level;
		end
	end

	// no conversion before the full settle time after any change
	always_ff @(posedge i_clk) begin
		last_route <= i_route;
		if (i_rst || !i_drive || i_route != last_route) begin
			wait_cnt <= 0;
			o_valid <= 1'b0;
		end else if (wait_cnt < P_SETTLE) begin
			wait_cnt <= wait_cnt + 1;
		end else begin
			o_valid <= 1'b1;
			o_reading <= level;
		end
	end
endmodule
`default_nettype wire

// ===== bench/tfam_top_assertions.sv
// port-level assertions for the thermal flag and selector block
`timescale 1ns/100ps
`default_nettype none
module tfam_checker #(
	parameter int unsigned P_WINDOW_CYC = 10,
	parameter int unsigned P_INTERVAL_CYC = 30
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// bus handshake
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	// power state and monitor
	input wire logic i_sys_on,
	input wire logic i_standby,
	input wire logic o_heat_watch_power,
	// selector and interrupt
	input wire logic [4:0] o_analog_selector_route,
	input wire logic o_analog_selector_drive,
	input wire logic o_analog_selector_pull_down,
	input wire logic o_analog_selector_settled,
	input wire logic o_irq
);
	localparam int SETTLE = tfam_pkg::SELECTOR_SETTLE_CYC;
	logic [4:0] route_prev;
	int settle_cnt;
	int pwr_run;
	int stby_run;

	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	// cycles since the routed channel last changed
	always_ff @(posedge i_core_clk) begin
		route_prev <= o_analog_selector_route;
		if (i_sys_rst || !o_analog_selector_drive || o_analog_selector_route != route_prev) begin
			settle_cnt <= 0;
		end else if (settle_cnt < 4000) begin
			settle_cnt <= settle_cnt + 1;
		end
	end

	// length of the current power-on run and of standby
	always_ff @(posedge i_core_clk) begin
		pwr_run <= (i_sys_rst || !o_heat_watch_power) ? 0 : pwr_run + 1;
		if (i_sys_rst || !i_standby) begin
			stby_run <= 0;
		end else if (stby_run < 1000) begin
			stby_run <= stby_run + 1;
		end
	end

	a_wait_first: assert property (
		$rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
		else $error("waitrequest low in first request cycle");
	a_wait_answer: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("no answer one cycle after request");
	a_drive_pull_apart: assert property (
		!(o_analog_selector_drive && o_analog_selector_pull_down))
		else $error("pin driven and pulled down together");
	a_drive_on_state: assert property (
		o_analog_selector_drive |-> $past(i_sys_on))
		else $error("pin driven outside on state");
	a_route_idle: assert property (
		!o_analog_selector_drive |-> o_analog_selector_route == 5'h00)
		else $error("route shown while not driving");
	a_route_assigned: assert property (
		o_analog_selector_drive |-> o_analog_selector_route inside
		{[5'h01:5'h08], 5'h0b, 5'h0c, [5'h0f:5'h14], 5'h17})
		else $error("reserved channel driven");
	a_settle_moment: assert property (
		$rose(o_analog_selector_settled) |-> settle_cnt >= SETTLE - 3 && settle_cnt <= SETTLE + 3)
		else $error("settled flag at wrong time");
	a_settle_late: assert property (
		settle_cnt == SETTLE + 3 |-> o_analog_selector_settled)
		else $error("settled flag missing");
	a_window_length: assert property (
		$fell(o_heat_watch_power) && stby_run > P_INTERVAL_CYC |-> pwr_run == P_WINDOW_CYC)
		else $error("sampling window length wrong");
	a_gap_off: assert property (
		$fell(o_heat_watch_power) && i_standby |-> !o_heat_watch_power [*8])
		else $error("monitor powered in gap");

	c_irq: cover property ($rose(o_irq));
	c_settled: cover property ($rose(o_analog_selector_settled));
	c_standby_gap: cover property ($fell(o_heat_watch_power) && i_standby);
endmodule

bind tfam_top tfam_checker #(.P_WINDOW_CYC(P_WINDOW_CYC), .P_INTERVAL_CYC(P_INTERVAL_CYC))
	tfam_checker_i (.i_core_clk, .i_sys_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
	.i_sys_on, .i_standby, .o_heat_watch_power, .o_analog_selector_route,
	.o_analog_selector_drive, .o_analog_selector_pull_down, .o_analog_selector_settled, .o_irq);
`default_nettype wire

// ===== bench/test_thermal_flags_and_analog_selector_select.sv
// self-checking bench for the thermal flag and selector block
`timescale 1ns/100ps
`default_nettype none
module test_thermal_flags_and_analog_selector_select;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hf;
	logic sys_on = 1'b0;
	logic stby = 1'b0;
	logic [5:0] rise = 6'h00;
	logic [5:0] fall = 6'h00;
	logic [31:0] rdata;
	logic wreq, pwr, drive, pull, settled, irq, valid;
	logic [4:0] route, reading;
	logic [31:0] v;
	int failures = 0;
	int n_compared = 0;
	int n;

	always #10 clk = ~clk;

	tfam_top #(.P_WINDOW_CYC(10), .P_INTERVAL_CYC(30)) tfam_top_i (.i_core_clk(clk),
		.i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_sys_on(sys_on), .i_standby(stby),
		.i_heat_rise_cmp(rise), .i_heat_fall_cmp(fall), .o_heat_watch_power(pwr),
		.o_analog_selector_route(route), .o_analog_selector_drive(drive),
		.o_analog_selector_pull_down(pull), .o_analog_selector_settled(settled), .o_irq(irq));

	tfam_sampler tfam_sampler_i (.i_clk(clk), .i_rst(rst), .i_drive(drive),
		.i_pull_down(pull), .i_route(route), .o_reading(reading), .o_valid(valid));

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic ticks(input int c);
		repeat (c) @(posedge clk);
	endtask

	// one avalon transfer; an idle cycle follows so strobes never re-rise at once
	task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 20);
		v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0) begin
			failures++;
			summarize();
		end
		@(posedge clk);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
		access(1'b0, a, 32'h0);
		check(what, v, exp);
	endtask

	// a whole number of intervals, so the count is independent of phase
	task automatic count_power(input logic [31:0] exp, input string what);
		logic [31:0] c;
		c = 32'h0;
		ticks(40);
		repeat (60) begin
			@(posedge clk);
			c = c + {31'h0, pwr};
		end
		check(what, c, exp);
	endtask

	function automatic logic assigned(input logic [4:0] code);
		return code inside {[5'h01:5'h08], 5'h0b, 5'h0c, [5'h0f:5'h14], 5'h17};
	endfunction

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd_chk(5'h0c, 32'h1, "watch");
		rd_chk(5'h08, 32'h0, "block");
		rd_chk(5'h10, 32'h0, "selector");
		rd_chk(5'h18, 32'h0, "unmapped");
		check("pull", {31'h0, pull}, 32'h1);
		// a write without the low byte lane must leave the mask alone
		be <= 4'h0;
		access(1'b1, 5'h08, 32'h3f);
		be <= 4'hf;
		rd_chk(5'h08, 32'h0, "byte enable");
		$display("reset test done");
		access(1'b1, 5'h0c, 32'h3);
		access(1'b1, 5'h08, 32'h3e);
		for (int k = 0; k < 6; k++) begin
			rise <= 6'h01 << k;
			fall <= 6'h01 << k;
			ticks(520);
			rd_chk(5'h04, 32'h1 << k, "live");
			rd_chk(5'h00, 32'h1 << k, "event");
			check("irq", {31'h0, irq}, (k == 0) ? 32'h1 : 32'h0);
			access(1'b1, 5'h00, 32'h1 << k);
			rd_chk(5'h00, 32'h0, "event clear");
			check("irq clear", {31'h0, irq}, 32'h0);
			rise <= 6'h00;
			ticks(520);
			rd_chk(5'h04, 32'h1 << k, "live held");
			fall <= 6'h00;
			ticks(520);
			rd_chk(5'h04, 32'h0, "live released");
		end
		$display("threshold test done");
		access(1'b1, 5'h0c, 32'h0);
		rise <= 6'h04;
		fall <= 6'h04;
		ticks(520);
		rd_chk(5'h04, 32'h0, "live off");
		rd_chk(5'h00, 32'h0, "event off");
		check("power off", {31'h0, pwr}, 32'h0);
		rise <= 6'h00;
		fall <= 6'h00;
		access(1'b1, 5'h0c, 32'h1);
		count_power(32'd20, "sampling");
		access(1'b1, 5'h0c, 32'h3);
		count_power(32'd60, "always on");
		stby <= 1'b1;
		count_power(32'd20, "standby");
		stby <= 1'b0;
		$display("monitor test done");
		sys_on <= 1'b1;
		for (int c = 0; c < 32; c++) begin
			access(1'b1, 5'h10, 32'h20 | 32'(c));
			ticks(2);
			check("route", 32'(route), assigned(5'(c)) ? 32'(c) : 32'h0);
			check("drive", {31'h0, drive}, {31'h0, assigned(5'(c))});
			check("pull", {31'h0, pull}, 32'h0);
		end
		access(1'b1, 5'h10, 32'h2f);
		n = 0;
		while (valid !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("settle wait", {31'h0, n >= 2500 && n < 3000}, 32'h1);
		check("reading", {27'h0, reading}, 32'hf);
		check("settled", {31'h0, settled}, 32'h1);
		// always on, not in standby, channel driven and settled
		rd_chk(5'h14, 32'hf, "state");
		access(1'b1, 5'h10, 32'h05);
		ticks(2);
		check("off drive", {31'h0, drive}, 32'h0);
		check("off pull", {31'h0, pull}, 32'h1);
		sys_on <= 1'b0;
		access(1'b1, 5'h10, 32'h21);
		ticks(2);
		check("not on drive", {31'h0, drive}, 32'h0);
		$display("selector test done");
		summarize();
	end
endmodule
`default_nettype wire
